/* File: verilog/dfcp_pkg.sv */
package dfcp_pkg;
	localparam int CMD_W    = 4;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 16;
	localparam int WORD_W   = 32;
	localparam int NCH      = 5;
	localparam int SEL_W    = 5;
	localparam int CH_IDX_W = 3;
	localparam int LEN_W    = 5;
	localparam int CMD_LSB  = 20;
	localparam int ADDR_LSB = 16;
	localparam int SHORT_W  = 8;

	localparam logic [CMD_W-1:0] CMD_UPD_CH     = 4'h1;
	localparam logic [CMD_W-1:0] CMD_WR_UPD_CH  = 4'h3;
	localparam logic [CMD_W-1:0] CMD_PD_CH      = 4'h4;
	localparam logic [CMD_W-1:0] CMD_PD_CHIP    = 4'h5;
	localparam logic [CMD_W-1:0] CMD_CONFIG     = 4'h7;
	localparam logic [CMD_W-1:0] CMD_UPD_ALL    = 4'h9;
	localparam logic [CMD_W-1:0] CMD_WR_UPD_ALL = 4'ha;
	localparam logic [CMD_W-1:0] CMD_MONITOR    = 4'hb;
	localparam logic [ADDR_W-1:0] ADDR_ALL      = 4'hf;

	localparam logic [SEL_W-1:0] SEL_OFF     = 5'h00;
	localparam logic [SEL_W-1:0] SEL_I_FIRST = 5'h01;
	localparam logic [SEL_W-1:0] SEL_I_LAST  = 5'h05;
	localparam logic [SEL_W-1:0] SEL_TEMP    = 5'h0a;
	localparam logic [SEL_W-1:0] SEL_V_FIRST = 5'h18;
	localparam logic [SEL_W-1:0] SEL_V_LAST  = 5'h1c;

	localparam int MON_SEL_LSB   = 0;
	localparam int CFG_OPEN_BIT  = 0;
	localparam int CFG_THERM_BIT = 1;
	localparam int CFG_REF_BIT   = 2;

	localparam logic [LEN_W-1:0] LEN_SHORT = 5'h18;
	localparam logic [LEN_W-1:0] LEN_WRAP  = 5'h00;
	localparam logic [LEN_W-1:0] LEN_LAST  = 5'h1f;

	localparam int SYS_CLK_MHZ  = 125;
	localparam int PRECHARGE_US = 7;
	localparam int PRECH_CYC    = PRECHARGE_US * SYS_CLK_MHZ;
	localparam int PRECH_W      = 10;
	localparam logic [PRECH_W-1:0] PRECH_LOAD = PRECH_W'(PRECH_CYC - 1);

	typedef enum logic [1:0] {MUX_OFF, MUX_PRECHARGE, MUX_LIVE} dfcp_mux_state_t;

	typedef struct packed {
		logic           bad_length_flag;
		logic           unused_status_bit;
		logic           overtemp_flag;
		logic [NCH-1:0] open_circuit_flag;
	} dfcp_fault_t;

	typedef struct packed {
		logic [CMD_W-1:0]  cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dfcp_cmd_t;

	typedef struct packed {
		logic ref_external;
		logic thermal_protect_disable;
		logic open_detect_disable;
	} dfcp_cfg_t;

	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic             precharge;
		logic             connect;
		logic             temp_route;
		logic             code_route;
	} dfcp_mon_t;
endpackage

/* File: verilog/dfcp_sync.sv */
`timescale 1ns/1ps
module dfcp_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1_reg;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1_reg <= '0;
			q          <= '0;
		end
		else
		begin
			stage1_reg <= d;
			q          <= stage1_reg;
		end
	end
endmodule

/* File: verilog/dfcp_link.sv */
`timescale 1ns/1ps
module dfcp_link
	import dfcp_pkg::*;
(
	input  wire logic              serial_clk,
	input  wire logic              rstn,
	input  wire logic              load_strobe_n,
	input  wire logic              serial_data_in,
	input  wire logic [WORD_W-1:0] echo_word,
	output logic      [WORD_W-1:0] frame_word,
	output logic      [LEN_W-1:0]  bit_low,
	output logic                   bit_multi,
	output logic                   frame_toggle,
	output logic                   serial_readback_out
);
	logic              armed_reg;
	logic              arm_rst_n;
	logic [WORD_W-1:0] readback_reg;

	// the strobe itself ends the frame, since the serial clock stops outside frames
	assign arm_rst_n = rstn & ~load_strobe_n;

	always_ff @(posedge serial_clk or negedge arm_rst_n)
	begin
		if (!arm_rst_n)
			armed_reg <= 1'b0;
		else
			armed_reg <= 1'b1;
	end

	// count and word stay put after the last edge; the system side reads them after the strobe
	always_ff @(posedge serial_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			frame_word   <= '0;
			bit_low      <= '0;
			bit_multi    <= 1'b0;
			frame_toggle <= 1'b0;
		end
		else if (!load_strobe_n)
		begin
			frame_word <= {frame_word[WORD_W-2:0], serial_data_in};
			if (!armed_reg)
			begin
				bit_low      <= LEN_W'(1);
				bit_multi    <= 1'b0;
				frame_toggle <= ~frame_toggle;
			end
			else
			begin
				bit_low   <= LEN_W'(bit_low + LEN_W'(1));
				bit_multi <= bit_multi | (bit_low == LEN_LAST);
			end
		end
	end

	// first edge loads the echo; incoming bits follow 32 edges later for daisy chains
	always_ff @(posedge serial_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			readback_reg        <= '0;
			serial_readback_out <= 1'b0;
		end
		else if (!load_strobe_n)
		begin
			if (!armed_reg)
			begin
				serial_readback_out <= echo_word[WORD_W-1];
				readback_reg        <= {echo_word[WORD_W-2:0], serial_data_in};
			end
			else
			begin
				serial_readback_out <= readback_reg[WORD_W-1];
				readback_reg        <= {readback_reg[WORD_W-2:0], serial_data_in};
			end
		end
	end
endmodule

/* File: verilog/dfcp_ctrl.sv */
`timescale 1ns/1ps
module dfcp_ctrl
	import dfcp_pkg::*;
(
	input  wire logic                         sys_clk,
	input  wire logic                         rstn,
	input  wire logic                         serial_clk,
	input  wire logic                         load_strobe_n,
	input  wire logic                         serial_data_in,
	output logic                              serial_readback_out,
	output logic                              serial_readback_oe,
	output logic                              fault_alert_out,
	output logic                              fault_alert_oe,
	input  wire logic [NCH-1:0]               dropout_detect,
	input  wire logic                         temp_above_trip,
	input  wire logic                         temp_below_release,
	input  wire logic [NCH-1:0]               toggle_update,
	input  wire logic [NCH-1:0][DATA_W-1:0]   dac_code,
	output dfcp_mon_t                         mon_ctrl,
	output logic      [DATA_W-1:0]            mon_code,
	output logic      [NCH-1:0]               chan_power_down,
	output logic                              ref_power_down,
	output dfcp_cfg_t                         config_bits,
	output dfcp_fault_t                       fault_status_byte
);
	localparam int SYNC_W = NCH + 4;

	logic [WORD_W-1:0] link_word;
	logic [LEN_W-1:0]  link_low;
	logic              link_multi;
	logic              link_toggle;
	logic [WORD_W-1:0] echo_snap_reg;
	logic [SYNC_W-1:0] sync_q;
	logic              tog_s;
	logic              strobe_s;
	logic [NCH-1:0]    dropout_s;
	logic              trip_s;
	logic              release_s;
	logic              strobe_d_reg;
	logic              tog_seen_reg;
	logic              frame_end;
	logic              frame_seen;
	logic              frame_ok;
	logic              cmd_take;
	logic              bad_frame;
	dfcp_cmd_t         rx;
	dfcp_cmd_t         echo_reg;
	dfcp_cfg_t         cfg_reg;
	logic [SEL_W-1:0]  mon_sel_reg;
	logic [SEL_W-1:0]  rx_sel;
	dfcp_mux_state_t   mux_state_reg;
	logic [PRECH_W-1:0] prech_cnt_reg;
	logic [DATA_W-1:0] sel_code;
	logic [NCH-1:0]    pd_ch_reg;
	logic [NCH-1:0]    pd_set;
	logic [NCH-1:0]    wake;
	logic              overtemp_reg;
	logic [NCH-1:0]    open_now;
	dfcp_fault_t       trig;
	dfcp_fault_t       trig_prev_reg;
	dfcp_fault_t       fault_sticky_reg;
	logic              alert_reg;
	logic              is_mon;

	function automatic logic [NCH-1:0] chan_mask(input logic [ADDR_W-1:0] a);
		logic [NCH-1:0] m;
		m = '0;
		if (a == ADDR_ALL)
			m = '1;
		else
			for (int i = 0; i < NCH; i++)
				if (a == ADDR_W'(i))
					m[i] = 1'b1;
		return m;
	endfunction
	function automatic logic is_current(input logic [SEL_W-1:0] s);
		return (s >= SEL_I_FIRST) && (s <= SEL_I_LAST);
	endfunction
	function automatic logic is_pin_volt(input logic [SEL_W-1:0] s);
		return (s >= SEL_V_FIRST) && (s <= SEL_V_LAST);
	endfunction
	function automatic logic [CH_IDX_W-1:0] sel_channel(input logic [SEL_W-1:0] s);
		logic [SEL_W-1:0] d;
		d = '0;
		if (is_current(s))
			d = SEL_W'(s - SEL_I_FIRST);
		else if (is_pin_volt(s))
			d = SEL_W'(s - SEL_V_FIRST);
		return d[CH_IDX_W-1:0];
	endfunction

	dfcp_link u_link (
		.serial_clk          (serial_clk),
		.rstn                (rstn),
		.load_strobe_n       (load_strobe_n),
		.serial_data_in      (serial_data_in),
		.echo_word           (echo_snap_reg),
		.frame_word          (link_word),
		.bit_low             (link_low),
		.bit_multi           (link_multi),
		.frame_toggle        (link_toggle),
		.serial_readback_out (serial_readback_out)
	);

	dfcp_sync #(.W(SYNC_W)) u_sync (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.d       ({link_toggle, load_strobe_n, dropout_detect, temp_above_trip,
			temp_below_release}),
		.q       (sync_q)
	);

	assign {tog_s, strobe_s, dropout_s, trip_s, release_s} = sync_q;
	assign serial_readback_oe = ~load_strobe_n;
	assign fault_alert_out    = 1'b0;
	assign fault_alert_oe     = alert_reg;

	// link word is quiet once the strobe has risen, so the synced edge qualifies it
	assign frame_end  = strobe_s & ~strobe_d_reg;
	assign frame_seen = tog_s != tog_seen_reg;
	assign frame_ok   = link_multi ? (link_low == LEN_WRAP) : (link_low == LEN_SHORT);
	assign cmd_take   = frame_end & frame_seen & frame_ok;
	assign bad_frame  = frame_end & frame_seen & ~frame_ok;
	assign rx.cmd     = link_word[CMD_LSB +: CMD_W];
	assign rx.addr    = link_word[ADDR_LSB +: ADDR_W];
	assign rx.data    = link_multi ? link_word[DATA_W-1:0]
		: {link_word[SHORT_W-1:0], {(DATA_W-SHORT_W){1'b0}}};
	assign rx_sel     = rx.data[MON_SEL_LSB +: SEL_W];
	assign is_mon     = cmd_take && (rx.cmd == CMD_MONITOR);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			strobe_d_reg <= 1'b0;
			tog_seen_reg <= 1'b0;
		end
		else
		begin
			strobe_d_reg <= strobe_s;
			if (frame_end)
				tog_seen_reg <= tog_s;
		end
	end

	// the echo shows the last accepted word; ignored frames leave it alone
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			echo_reg <= '0;
		else if (cmd_take)
			echo_reg <= rx;
	end
	// frozen while the strobe is low so the link samples a steady word
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			echo_snap_reg <= '0;
		else if (strobe_s)
			echo_snap_reg <= {fault_sticky_reg, echo_reg};
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			cfg_reg <= '0;
		else if (cmd_take && (rx.cmd == CMD_CONFIG))
		begin
			cfg_reg.open_detect_disable     <= rx.data[CFG_OPEN_BIT];
			cfg_reg.thermal_protect_disable <= rx.data[CFG_THERM_BIT];
			cfg_reg.ref_external            <= rx.data[CFG_REF_BIT];
		end
	end
	assign config_bits = cfg_reg;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			mon_sel_reg <= SEL_OFF;
		else if (is_mon)
			mon_sel_reg <= rx_sel;
	end
	// precharge also covers current selections: cheap and keeps one valid-delay for the host
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mux_state_reg <= MUX_OFF;
			prech_cnt_reg <= '0;
		end
		else if (is_mon)
		begin
			prech_cnt_reg <= PRECH_LOAD;
			if (is_current(rx_sel) || is_pin_volt(rx_sel))
				mux_state_reg <= MUX_PRECHARGE;
			else if (rx_sel == SEL_OFF)
				mux_state_reg <= MUX_OFF;
			else
				mux_state_reg <= MUX_LIVE;
		end
		else
		begin
			case (mux_state_reg)
				MUX_PRECHARGE:
				begin
					if (prech_cnt_reg == '0)
						mux_state_reg <= MUX_LIVE;
					else
						prech_cnt_reg <= PRECH_W'(prech_cnt_reg - PRECH_W'(1));
				end
				MUX_OFF,
				MUX_LIVE:
					mux_state_reg <= mux_state_reg;
				default:
					mux_state_reg <= MUX_OFF;
			endcase
		end
	end
	assign sel_code = dac_code[sel_channel(mon_sel_reg)];
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mon_ctrl <= '0;
			mon_code <= '0;
		end
		else
		begin
			mon_ctrl.sel        <= mon_sel_reg;
			mon_ctrl.precharge  <= mux_state_reg == MUX_PRECHARGE;
			mon_ctrl.connect    <= mux_state_reg == MUX_LIVE;
			mon_ctrl.temp_route <= (mux_state_reg == MUX_LIVE) && (mon_sel_reg == SEL_TEMP);
			mon_ctrl.code_route <= (mux_state_reg == MUX_LIVE) && is_current(mon_sel_reg);
			mon_code            <= is_current(mon_sel_reg) ? sel_code : '0;
		end
	end

	// power-down commands look only at command and address, never the data
	always_comb
	begin
		pd_set = '0;
		wake   = toggle_update;
		if (cmd_take)
		begin
			case (rx.cmd)
				CMD_PD_CH:
					pd_set = chan_mask(rx.addr);
				CMD_PD_CHIP:
					pd_set = '1;
				CMD_UPD_CH,
				CMD_WR_UPD_CH:
					wake = wake | chan_mask(rx.addr);
				CMD_UPD_ALL,
				CMD_WR_UPD_ALL:
					wake = '1;
				default:
					pd_set = '0;
			endcase
		end
	end

	// separate state from the config and monitor registers, so they survive power-down
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pd_ch_reg      <= '0;
			ref_power_down <= 1'b0;
		end
		else
		begin
			pd_ch_reg <= (pd_ch_reg & ~wake) | pd_set;
			if (cmd_take && (rx.cmd == CMD_PD_CHIP))
				ref_power_down <= 1'b1;
			else if (|wake)
				ref_power_down <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			chan_power_down <= '0;
		else
			chan_power_down <= pd_ch_reg | {NCH{overtemp_reg}};
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			overtemp_reg <= 1'b0;
		else if (cfg_reg.thermal_protect_disable)
			overtemp_reg <= 1'b0;
		else if (trip_s)
			overtemp_reg <= 1'b1;
		else if (release_s)
			overtemp_reg <= 1'b0;
	end
	assign open_now                = dropout_s & ~{NCH{cfg_reg.open_detect_disable}};
	assign trig.bad_length_flag    = bad_frame;
	assign trig.unused_status_bit  = 1'b0;
	assign trig.overtemp_flag      = overtemp_reg;
	assign trig.open_circuit_flag  = open_now;
	// a trigger arriving with the strobe edge survives into the next word
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fault_sticky_reg <= '0;
			trig_prev_reg    <= '0;
		end
		else
		begin
			trig_prev_reg <= trig;
			if (frame_end)
				fault_sticky_reg <= trig;
			else
				fault_sticky_reg <= fault_sticky_reg | trig;
		end
	end
	assign fault_status_byte = fault_sticky_reg;
	// only a new fault pulls the line, so a strobe frees it even while hot
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			alert_reg <= 1'b0;
		else if (|(trig & ~trig_prev_reg))
			alert_reg <= 1'b1;
		else if (frame_end)
			alert_reg <= 1'b0;
	end
	AST_MON_LOAD: assert property (@(posedge sys_clk) disable iff (!rstn)
		is_mon |=> mon_sel_reg == $past(rx_sel))
		else $error("monitor selection not loaded");
	AST_MON_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
		!is_mon |=> $stable(mon_sel_reg))
		else $error("monitor selection changed without command");
	AST_TEMP_ROUTE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mux_state_reg == MUX_LIVE && mon_sel_reg == SEL_TEMP) |=> mon_ctrl.temp_route)
		else $error("temperature not routed");
	AST_CODE_ROUTE: assert property (@(posedge sys_clk) disable iff (!rstn)
		is_current(mon_sel_reg) |=> mon_code == $past(sel_code))
		else $error("monitor code not from channel code");
	AST_PRECHARGE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(is_mon && (is_current(rx_sel) || is_pin_volt(rx_sel)))
		|=> ##1 (!mon_ctrl.connect && mon_ctrl.precharge)[*8])
		else $error("connected before precharge");
	AST_OT_POWERDOWN: assert property (@(posedge sys_clk) disable iff (!rstn)
		overtemp_reg |=> chan_power_down == {NCH{1'b1}} && fault_sticky_reg.overtemp_flag)
		else $error("overtemperature did not power down");
	AST_OT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
		(overtemp_reg && !release_s && !cfg_reg.thermal_protect_disable) |=> overtemp_reg)
		else $error("overtemperature released while hot");
	AST_BAD_LENGTH: assert property (@(posedge sys_clk) disable iff (!rstn)
		bad_frame |=> fault_sticky_reg.bad_length_flag && alert_reg && $stable(echo_reg))
		else $error("bad length not flagged");
	AST_UNUSED_BIT: assert property (@(posedge sys_clk) disable iff (!rstn)
		!fault_sticky_reg.unused_status_bit && !echo_snap_reg[WORD_W-2])
		else $error("unused status bit set");
	AST_ALERT_RELEASE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(frame_end && (trig & ~trig_prev_reg) == '0) |=> !fault_alert_oe)
		else $error("alert not released at strobe");
	AST_OPEN_DISABLE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(frame_end && cfg_reg.open_detect_disable) |=> fault_sticky_reg.open_circuit_flag == '0)
		else $error("open circuit flagged while disabled");
	AST_PD_KEEPS: assert property (@(posedge sys_clk) disable iff (!rstn)
		(cmd_take && (rx.cmd == CMD_PD_CH || rx.cmd == CMD_PD_CHIP))
		|=> $stable(cfg_reg) && $stable(mon_sel_reg))
		else $error("power-down disturbed registers");
endmodule

/* File: verification/dfcp_host.sv */
`timescale 1ns/1ps
module dfcp_host (
	output logic      serial_clk,
	output logic      load_strobe_n,
	output logic      serial_data_in,
	input  wire logic serial_readback_out
);
	initial
	begin
		serial_clk = 1'b0;
		load_strobe_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// msb first; the link clock stands still between frames
	task automatic frame(input logic [31:0] w, input int n, output logic [31:0] rb);
		rb = '0;
		load_strobe_n <= 1'b0;
		#30;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_data_in <= w[i];
			#7.5 serial_clk <= 1'b1;
			#3 rb = {rb[30:0], serial_readback_out};
			#4.5 serial_clk <= 1'b0;
		end
		#7.5 load_strobe_n <= 1'b1;
		// released data line toggles so a stale bit is never mistaken for data
		serial_data_in <= ~serial_data_in;
		#100;
	endtask
	task automatic mon_wait;
		#7200;
	endtask
	task automatic wake_wait(input logic chip);
		if (chip)
			#35000;
		else
			#30000;
	endtask
endmodule

/* File: verification/test_dfcp_ctrl.sv */
`timescale 1ns/1ps
module test_dfcp_ctrl
	import dfcp_pkg::*;
;
	logic                       sys_clk;
	logic                       rstn;
	logic                       serial_clk;
	logic                       load_strobe_n;
	logic                       serial_data_in;
	logic                       serial_readback_out;
	logic                       serial_readback_oe;
	logic                       fault_alert_out;
	logic                       fault_alert_oe;
	logic [NCH-1:0]             dropout_detect;
	logic                       temp_above_trip;
	logic                       temp_below_release;
	logic [NCH-1:0]             toggle_update;
	logic [NCH-1:0][DATA_W-1:0] dac_code;
	dfcp_mon_t                  mon_ctrl;
	logic [DATA_W-1:0]          mon_code;
	logic [NCH-1:0]             chan_power_down;
	logic                       ref_power_down;
	dfcp_cfg_t                  config_bits;
	dfcp_fault_t                fault_status_byte;
	logic [31:0]                rb;
	int                         n_errors;
	int                         checks_done;
	int                         cyc;

	dfcp_host host (
		.serial_clk          (serial_clk),
		.load_strobe_n       (load_strobe_n),
		.serial_data_in      (serial_data_in),
		.serial_readback_out (serial_readback_out)
	);

	dfcp_ctrl DUT (
		.sys_clk             (sys_clk),
		.rstn                (rstn),
		.serial_clk          (serial_clk),
		.load_strobe_n       (load_strobe_n),
		.serial_data_in      (serial_data_in),
		.serial_readback_out (serial_readback_out),
		.serial_readback_oe  (serial_readback_oe),
		.fault_alert_out     (fault_alert_out),
		.fault_alert_oe      (fault_alert_oe),
		.dropout_detect      (dropout_detect),
		.temp_above_trip     (temp_above_trip),
		.temp_below_release  (temp_below_release),
		.toggle_update       (toggle_update),
		.dac_code            (dac_code),
		.mon_ctrl            (mon_ctrl),
		.mon_code            (mon_code),
		.chan_power_down     (chan_power_down),
		.ref_power_down      (ref_power_down),
		.config_bits         (config_bits),
		.fault_status_byte   (fault_status_byte)
	);

	initial
	begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		dropout_detect = '0;
		temp_above_trip = 1'b0;
		temp_below_release = 1'b1;
		toggle_update = '0;
		for (int i = 0; i < NCH; i++)
			dac_code[i] = 16'h1000 + 16'(i * 16'h0111);
		n_errors = 0;
		checks_done = 0;
		cyc = 0;
	end

	always #4 sys_clk = ~sys_clk;

	// ceiling is about twice the expected length of the run
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 13000)
		begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	function automatic logic [31:0] word(logic [3:0] c, logic [3:0] a, logic [15:0] d);
		return {8'h00, c, a, d};
	endfunction

	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		cycles(4);
		rstn <= 1'b1;
		cycles(3);
		chk(mon_ctrl.sel, SEL_OFF, "sel at reset");
		chk(config_bits, 3'h0, "config at reset");
		chk(fault_status_byte, 8'h00, "status at reset");
		chk({fault_alert_out, fault_alert_oe, serial_readback_oe}, 3'b000, "pins idle");
		$display("test reset done");

		host.frame(word(CMD_MONITOR, 4'h0, 16'h0002), 32, rb);
		cycles(8);
		chk(mon_ctrl.sel, 5'h02, "monitor sel");
		chk({mon_ctrl.precharge, mon_ctrl.connect}, 2'b10, "precharge first");
		chk(mon_code, dac_code[1], "code route value");
		host.mon_wait();
		chk({mon_ctrl.connect, mon_ctrl.code_route}, 2'b11, "connected");
		host.frame(word(CMD_MONITOR, 4'h0, {11'h0, SEL_V_FIRST}), 32, rb);
		chk(rb, word(CMD_MONITOR, 4'h0, 16'h0002), "echo word");
		cycles(8);
		chk({mon_ctrl.precharge, mon_ctrl.connect}, 2'b10, "pin precharge");
		chk(mon_code, 16'h0000, "no code for pin");
		host.frame(word(CMD_MONITOR, 4'h0, {11'h0, SEL_TEMP}), 32, rb);
		chk(rb, word(CMD_MONITOR, 4'h0, {11'h0, SEL_V_FIRST}), "echo pin word");
		cycles(8);
		chk({mon_ctrl.temp_route, mon_ctrl.connect}, 2'b11, "temp route");
		$display("test monitor done");

		host.frame(32'h000b_0001, 20, rb);
		cycles(8);
		chk({fault_alert_oe, fault_alert_out}, 2'b10, "alert on bad length");
		chk(fault_status_byte, 8'h80, "bad length flag");
		chk(mon_ctrl.sel, SEL_TEMP, "bad frame ignored");
		host.frame({8'h00, CMD_PD_CH, 4'h2, 8'hff, 8'h00}, 24, rb);
		chk(rb[23:0], {8'h80, CMD_MONITOR, 4'h0, 8'h00}, "status then echo");
		cycles(8);
		chk(chan_power_down, 5'b00100, "channel pd");
		chk(fault_alert_oe, 1'b0, "alert released");
		chk(fault_status_byte, 8'h00, "status refreshed");
		$display("test length done");

		host.frame(word(CMD_PD_CHIP, 4'h0, 16'hffff), 32, rb);
		cycles(8);
		chk({ref_power_down, chan_power_down}, 6'h3f, "chip pd");
		chk(mon_ctrl.sel, SEL_TEMP, "pd keeps registers");
		toggle_update <= 5'b00001;
		cycles(4);
		toggle_update <= 5'b00000;
		cycles(2);
		chk(chan_power_down[0], 1'b0, "toggle wakes");
		host.frame(word(CMD_UPD_CH, 4'h1, 16'h0000), 32, rb);
		cycles(8);
		chk(chan_power_down, 5'b11100, "update wakes ch1");
		host.frame(word(CMD_WR_UPD_ALL, ADDR_ALL, 16'h0123), 32, rb);
		cycles(8);
		chk({ref_power_down, chan_power_down}, 6'h00, "update wakes");
		host.wake_wait(1'b1);
		$display("test power done");

		dropout_detect <= 5'b01000;
		cycles(8);
		chk(fault_status_byte, 8'h08, "open flag ch3");
		chk(fault_alert_oe, 1'b1, "alert on open");
		dropout_detect <= 5'b00000;
		temp_above_trip <= 1'b1;
		temp_below_release <= 1'b0;
		cycles(8);
		chk(fault_status_byte, 8'h28, "overtemp flag");
		chk(chan_power_down, 5'h1f, "overtemp shutdown");
		host.frame(word(CMD_MONITOR, 4'h0, {11'h0, SEL_TEMP}), 32, rb);
		cycles(8);
		chk(fault_alert_oe, 1'b0, "alert released hot");
		chk({fault_status_byte, chan_power_down}, {8'h20, 5'h1f}, "still hot");
		temp_above_trip <= 1'b0;
		temp_below_release <= 1'b1;
		cycles(6);
		host.frame(word(CMD_MONITOR, 4'h0, {11'h0, SEL_TEMP}), 32, rb);
		cycles(8);
		chk({fault_status_byte, chan_power_down}, 13'h0, "cooled");
		$display("test fault done");

		host.frame(word(CMD_CONFIG, 4'h0, 16'h0007), 32, rb);
		cycles(8);
		chk(config_bits, 3'b111, "config bits");
		dropout_detect <= 5'b00010;
		temp_above_trip <= 1'b1;
		cycles(8);
		chk(fault_status_byte, 8'h00, "detection disabled");
		chk({fault_alert_oe, chan_power_down}, 6'h00, "no shutdown");
		$display("test config done");
		finish_test();
	end
endmodule
